/* dhp_host_port.sv */
// host register port of a two-channel serial controller, both bus variants
`timescale 1ns/1ps
`default_nettype none

module dhp_host_port
	import dhp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_mux_mode,
	input wire dhp_pkg::dhp_nmux_bus_t i_nmux,
	input wire dhp_pkg::dhp_mux_bus_t i_mux,
	input wire logic [7:0] i_data,
	input wire logic i_chain_enable_in,
	input wire logic [5:0] i_pending,
	input wire dhp_pkg::dhp_chan_status_t i_status_a,
	input wire dhp_pkg::dhp_chan_status_t i_status_b,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_chain_enable_out,
	output logic o_int_n,
	output logic [5:0] o_in_service,
	output logic [1:0] o_tx_load,
	output logic [7:0] o_tx_data,
	output logic [1:0] o_rx_read,
	output logic [7:0] o_vector,
	output logic [7:0] o_master,
	output logic [127:0] o_wreg_a,
	output logic [127:0] o_wreg_b
);
	import dhp_pkg::*;

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_meta_q;
	logic rst_n;

	// async assert, two-flop release
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// ****************************************************************
	// strobe synchronisers
	// ****************************************************************
	// bit order {ack, rd, wr, as, ds}
	logic [4:0] raw;
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] sync3_q;
	logic [4:0] fall;
	logic [4:0] rise;

	// effective rd and wr strobes are the overlap with chip enable
	always_comb
	begin
		raw[4] = i_mux_mode ? !i_mux.interrupt_ack_n : !i_nmux.interrupt_ack_n;
		raw[3] = !i_mux_mode && !i_nmux.chip_en_n && !i_nmux.rd_n;
		raw[2] = !i_mux_mode && !i_nmux.chip_en_n && !i_nmux.wr_n;
		raw[1] = i_mux_mode && !i_mux.address_strobe_n;
		raw[0] = i_mux_mode && !i_mux.data_strobe_n;
	end

	// two flops resolve metastability, third for edges and the ack level in the pointer clear
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			sync3_q <= 5'h00;
		end
		else
		begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// strobe active edge = fall of pin, end = rise of pin
	assign fall = sync2_q & ~sync3_q;
	assign rise = ~sync2_q & sync3_q;

	// ****************************************************************
	// pin sampling while strobes are low
	// ****************************************************************
	logic [7:0] wdata_q;
	logic [7:0] ad_hold_q;
	logic cs0_hold_q;
	logic ack_hold_q;
	logic rw_hold_q;
	logic cs1_hold_q;

	// last value seen while the pin strobe was low survives the sync lag
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdata_q <= RESET_BYTE;
			ad_hold_q <= RESET_BYTE;
			cs0_hold_q <= 1'b1;
			ack_hold_q <= 1'b0;
			rw_hold_q <= 1'b1;
			cs1_hold_q <= 1'b0;
		end
		else
		begin
			if (raw[2] || (raw[0] && !i_mux.rw))
				wdata_q <= i_data; // data valid up to the strobe rise
			if (raw[1])
			begin
				ad_hold_q <= i_data;
				cs0_hold_q <= i_mux.cs0_n;
				ack_hold_q <= !i_mux.interrupt_ack_n;
			end
			if (raw[0])
			begin
				rw_hold_q <= i_mux.rw;
				cs1_hold_q <= i_mux.cs1;
			end
		end
	end

	// ****************************************************************
	// register state
	// ****************************************************************
	logic [7:0] wreg_q [2][REG_CNT];
	logic [7:0] vector_q;
	logic [7:0] master_q;
	logic [3:0] ptr_q;
	logic [5:0] ius_q;
	logic acc_ch_q;
	logic [3:0] acc_idx_q;
	logic acc_data_q;
	logic mux_sel_q;
	logic mux_ack_q;

	// ****************************************************************
	// access decode
	// ****************************************************************
	logic [1:0] shift_mode;
	logic dec_ch;
	logic [3:0] dec_idx;
	logic cur_ch;
	logic [3:0] cur_idx;
	logic start_rd;
	logic start_ack;
	logic end_wr;
	logic end_rd;

	// decode mode lives in channel B pointer register
	assign shift_mode = wreg_q[1][IDX_POINTER][1:0];

	// channel 0 = A: pin high selects A
	always_comb
	begin
		if (shift_mode == SHIFT_RIGHT)
			dec_ch = !ad_hold_q[AD_CHAN_RIGHT];
		else
			dec_ch = !ad_hold_q[AD_CHAN_LEFT];
		dec_idx = ad_hold_q[4:1];
		if (i_mux_mode)
		begin
			cur_ch = acc_ch_q;
			cur_idx = acc_idx_q;
		end
		else
		begin
			cur_ch = !i_nmux.chan_a_bn;
			cur_idx = i_nmux.data_ctrl ? IDX_DATA : ptr_q;
		end
	end

	// events; host spacing keeps them from overlapping
	always_comb
	begin
		if (i_mux_mode)
		begin
			start_ack = fall[0] && mux_ack_q;
			start_rd = fall[0] && !mux_ack_q && mux_sel_q && cs1_hold_q && rw_hold_q;
			end_wr = rise[0] && !mux_ack_q && mux_sel_q && cs1_hold_q && !rw_hold_q;
			end_rd = rise[0];
		end
		else
		begin
			start_ack = fall[3] && sync2_q[4];
			start_rd = fall[3] && !sync2_q[4];
			end_wr = rise[2] && !sync2_q[4];
			end_rd = rise[3];
		end
	end

	// target latched at address strobe end, or at nmux strobe fall
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_ch_q <= 1'b0;
			acc_idx_q <= IDX_POINTER;
			acc_data_q <= 1'b0;
			mux_sel_q <= 1'b0;
			mux_ack_q <= 1'b0;
		end
		else if (i_mux_mode && rise[1])
		begin
			acc_ch_q <= dec_ch;
			acc_idx_q <= dec_idx;
			acc_data_q <= 1'b0;
			mux_sel_q <= !cs0_hold_q;
			mux_ack_q <= ack_hold_q;
		end
		else if (!i_mux_mode && (fall[3] || fall[2]))
		begin
			acc_ch_q <= cur_ch;
			acc_idx_q <= cur_idx;
			acc_data_q <= i_nmux.data_ctrl;
		end
	end

	// ****************************************************************
	// interrupt vector and priority
	// ****************************************************************
	logic [5:0] elig;
	logic [5:0] top_elig;
	logic [5:0] top_ius;
	logic [2:0] vcode;
	logic [7:0] vec_mod;

	// highest priority is bit 5 (channel A receive)
	always_comb
	begin
		elig = master_q[MIE_BIT] ? (i_pending & ~ius_q) : 6'h00;
		top_elig = 6'h00;
		top_ius = 6'h00;
		for (int i = 0; i < 6; i++)
		begin
			if (elig[i])
				top_elig = 6'(1 << i);
			if (ius_q[i])
				top_ius = 6'(1 << i);
		end
		case (top_elig)
			6'h20: vcode = VC_A_RX;
			6'h10: vcode = VC_A_TX;
			6'h08: vcode = VC_A_EXT;
			6'h04: vcode = VC_B_RX;
			6'h02: vcode = VC_B_TX;
			6'h01: vcode = VC_B_EXT;
			default: vcode = VC_NONE;
		endcase
		vec_mod = {vector_q[7:4], vcode, vector_q[0]};
	end

	// ****************************************************************
	// read data selection
	// ****************************************************************
	logic [7:0] rd_value;
	dhp_chan_status_t st;
	logic fifo_en;

	always_comb
	begin
		st = cur_ch ? i_status_b : i_status_a;
		fifo_en = wreg_q[cur_ch][IDX_EXTEN][FIFO_EN_BIT];
		case (cur_idx)
			IDX_POINTER, IDX_IMG_LINE: rd_value = st.line;
			IDX_SPECIAL, IDX_IMG_SPECIAL: rd_value = st.special;
			IDX_VECTOR: rd_value = cur_ch ? vec_mod : vector_q;
			IDX_PENDING: rd_value = cur_ch ? 8'h00 : {2'h0, i_pending};
			IDX_FRAME_LO: rd_value = fifo_en ? st.frame_lo : (cur_ch ? vec_mod : vector_q);
			IDX_FRAME_HI: rd_value = fifo_en ? st.frame_hi :
				(cur_ch ? 8'h00 : {2'h0, i_pending});
			IDX_DATA: rd_value = st.rx_data;
			IDX_LOOP, IDX_IMG_LOOP: rd_value = st.loop_clk;
			IDX_BAUD_LO: rd_value = wreg_q[cur_ch][IDX_BAUD_LO];
			IDX_BAUD_HI, IDX_MASTER: rd_value = wreg_q[cur_ch][IDX_BAUD_HI];
			IDX_EXTEN, IDX_IMG_EXTEN: rd_value = wreg_q[cur_ch][IDX_EXTEN];
			default: rd_value = RESET_BYTE;
		endcase
	end

	// ****************************************************************
	// data bus drive
	// ****************************************************************
	// ack cycle with chain enable in and an eligible source puts the vector out; plain reads put out the register
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_data <= RESET_BYTE;
			o_data_oe <= 1'b0;
		end
		else if (start_ack && |elig && i_chain_enable_in)
		begin
			o_data <= master_q[VIS_BIT] ? vec_mod : vector_q;
			o_data_oe <= 1'b1;
		end
		else if (start_rd)
		begin
			o_data <= rd_value;
			o_data_oe <= 1'b1;
		end
		else if (end_rd)
			o_data_oe <= 1'b0;
	end

	// ****************************************************************
	// pointer
	// ****************************************************************
	// only the non-multiplexed bus uses it
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ptr_q <= IDX_POINTER;
		else if (!i_mux_mode && end_wr && !acc_data_q)
		begin
			if (acc_idx_q == IDX_POINTER)
			begin
				ptr_q <= {1'b0, wdata_q[PTR_MSB:0]};
				if (wdata_q[CMD_MSB:CMD_LSB] == CMD_POINT_HIGH)
					ptr_q <= {1'b0, wdata_q[PTR_MSB:0]} + POINT_HIGH_ADD;
			end
			else
				ptr_q <= IDX_POINTER;
		end
		else if (!i_mux_mode && end_rd && !acc_data_q && !sync3_q[4])
			ptr_q <= IDX_POINTER;
	end

	// ****************************************************************
	// write registers
	// ****************************************************************
	logic [1:0] mrst;

	// reset command field of the master register write
	assign mrst = (end_wr && acc_idx_q == IDX_MASTER) ? wdata_q[7:6] : 2'h0;

	// per channel array plus shared vector and master
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vector_q <= RESET_BYTE;
			master_q <= RESET_BYTE;
			for (int c = 0; c < 2; c++)
				for (int r = 0; r < REG_CNT; r++)
					wreg_q[c][r] <= RESET_BYTE;
		end
		else if (end_wr)
		begin
			if (acc_idx_q == IDX_VECTOR)
				vector_q <= wdata_q;
			else if (acc_idx_q == IDX_MASTER)
				master_q <= wdata_q;
			else if (acc_idx_q != IDX_DATA)
				wreg_q[acc_ch_q][acc_idx_q] <= wdata_q;
			// channel and hardware reset commands clear channel registers
			for (int r = 0; r < REG_CNT; r++)
			begin
				if (mrst == MRST_HW || mrst == MRST_CHA)
					wreg_q[0][r] <= RESET_BYTE;
				if (mrst == MRST_HW || mrst == MRST_CHB)
					wreg_q[1][r] <= RESET_BYTE;
			end
		end
	end

	// ****************************************************************
	// transmit buffer and receive read pulses
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_tx_load <= 2'h0;
			o_tx_data <= RESET_BYTE;
			o_rx_read <= 2'h0;
		end
		else
		begin
			o_tx_load <= 2'h0;
			o_rx_read <= 2'h0;
			if (end_wr && acc_idx_q == IDX_DATA)
			begin
				o_tx_load[acc_ch_q] <= 1'b1;
				o_tx_data <= wdata_q;
			end
			if (start_rd && cur_idx == IDX_DATA)
				o_rx_read[cur_ch] <= 1'b1;
		end
	end

	// ****************************************************************
	// in-service latches and daisy chain
	// ****************************************************************
	// a reset-in-service command and a same-cycle acknowledge on another bit both take effect
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ius_q <= 6'h00;
		else if (mrst == MRST_HW)
			ius_q <= 6'h00;
		else
		begin
			if (end_wr && acc_idx_q == IDX_POINTER &&
				wdata_q[CMD_MSB:CMD_LSB] == CMD_RESET_IUS)
				ius_q <= (ius_q & ~top_ius) |
					((start_ack && i_chain_enable_in) ? top_elig : 6'h00);
			else if (start_ack && i_chain_enable_in)
				ius_q <= ius_q | top_elig;
		end
	end

	// chain passes only when nothing here is served or claiming an ack
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_chain_enable_out <= 1'b0;
			o_int_n <= 1'b1;
		end
		else
		begin
			o_chain_enable_out <= i_chain_enable_in && !(|ius_q) &&
				!(sync2_q[4] && |elig);
			o_int_n <= !(i_chain_enable_in && !(|ius_q) && |elig);
		end
	end

	// ****************************************************************
	// register outputs
	// ****************************************************************
	assign o_vector = vector_q;
	assign o_master = master_q;
	assign o_in_service = ius_q;

	genvar g;
	for (g = 0; g < REG_CNT; g++)
	begin : g_wreg
		assign o_wreg_a[g*8 +: 8] = wreg_q[0][g];
		assign o_wreg_b[g*8 +: 8] = wreg_q[1][g];
	end

endmodule

`default_nettype wire

/* dhp_pkg.sv */
// constants and bus carriers for the dual-channel host register port
package dhp_pkg;

	// ****************************************************************
	// register indices
	// ****************************************************************
	localparam logic [3:0] IDX_POINTER = 4'h0;
	localparam logic [3:0] IDX_SPECIAL = 4'h1;
	localparam logic [3:0] IDX_VECTOR = 4'h2;
	localparam logic [3:0] IDX_PENDING = 4'h3;
	localparam logic [3:0] IDX_IMG_LINE = 4'h4;
	localparam logic [3:0] IDX_IMG_SPECIAL = 4'h5;
	localparam logic [3:0] IDX_FRAME_LO = 4'h6;
	localparam logic [3:0] IDX_FRAME_HI = 4'h7;
	localparam logic [3:0] IDX_DATA = 4'h8;
	localparam logic [3:0] IDX_MASTER = 4'h9;
	localparam logic [3:0] IDX_LOOP = 4'ha;
	localparam logic [3:0] IDX_IMG_EXTEN = 4'hb;
	localparam logic [3:0] IDX_BAUD_LO = 4'hc;
	localparam logic [3:0] IDX_BAUD_HI = 4'hd;
	localparam logic [3:0] IDX_IMG_LOOP = 4'he;
	localparam logic [3:0] IDX_EXTEN = 4'hf;
	localparam int REG_CNT = 16;

	// ****************************************************************
	// field layouts and command codes
	// ****************************************************************
	localparam int PTR_MSB = 2;
	localparam int CMD_LSB = 3;
	localparam int CMD_MSB = 5;
	localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
	localparam logic [2:0] CMD_RESET_IUS = 3'h7;
	localparam logic [3:0] POINT_HIGH_ADD = 4'h8;
	localparam logic [1:0] SHIFT_LEFT = 2'h2;
	localparam logic [1:0] SHIFT_RIGHT = 2'h3;
	localparam int FIFO_EN_BIT = 2;
	localparam int MIE_BIT = 3;
	localparam int VIS_BIT = 0;
	localparam logic [1:0] MRST_HW = 2'h3;
	localparam logic [1:0] MRST_CHA = 2'h2;
	localparam logic [1:0] MRST_CHB = 2'h1;
	localparam int AD_CHAN_RIGHT = 0;
	localparam int AD_CHAN_LEFT = 5;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// vector status codes, pending order {a_rx,a_tx,a_ext,b_rx,b_tx,b_ext}
	localparam logic [2:0] VC_A_RX = 3'h6;
	localparam logic [2:0] VC_A_TX = 3'h4;
	localparam logic [2:0] VC_A_EXT = 3'h5;
	localparam logic [2:0] VC_B_RX = 3'h2;
	localparam logic [2:0] VC_B_TX = 3'h0;
	localparam logic [2:0] VC_B_EXT = 3'h1;
	localparam logic [2:0] VC_NONE = 3'h3;

	// host spacing between strobe falls, in peripheral clocks
	localparam int RECOVERY_PCLKS = 3;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic chip_en_n;
		logic rd_n;
		logic wr_n;
		logic data_ctrl;
		logic chan_a_bn;
		logic interrupt_ack_n;
	} dhp_nmux_bus_t;

	typedef struct packed {
		logic address_strobe_n;
		logic data_strobe_n;
		logic rw;
		logic cs0_n;
		logic cs1;
		logic interrupt_ack_n;
	} dhp_mux_bus_t;

	typedef struct packed {
		logic [7:0] line;
		logic [7:0] special;
		logic [7:0] loop_clk;
		logic [7:0] frame_lo;
		logic [7:0] frame_hi;
		logic [7:0] rx_data;
	} dhp_chan_status_t;

endpackage

/* dhp_host_port_chk.sv */
// assertion checker for the host register port
`timescale 1ns/1ps
`default_nettype none

module dhp_host_port_chk
	import dhp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_mux_mode,
	input wire dhp_pkg::dhp_nmux_bus_t i_nmux,
	input wire logic i_chain_enable_in,
	input wire logic [5:0] i_pending,
	input wire logic o_data_oe,
	input wire logic o_int_n,
	input wire logic [5:0] o_in_service,
	input wire logic [1:0] o_tx_load,
	input wire logic [1:0] o_rx_read,
	input wire logic [7:0] o_master
);
	import dhp_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	logic [3:0] hi_cnt_q;
	logic [5:0] ius_q;
	logic [5:0] new_ius;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	// cycles since the read strobe was last low; saturates so it never wraps
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hi_cnt_q <= 4'h0;
		else if (!i_nmux.rd_n)
			hi_cnt_q <= 4'h0;
		else if (hi_cnt_q != 4'hf)
			hi_cnt_q <= hi_cnt_q + 4'h1;
	end

	// in-service bits that came up this cycle
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			ius_q <= 6'h00;
		else
			ius_q <= o_in_service;
	end
	assign new_ius = o_in_service & ~ius_q;

	// ****************************************************************
	// sequences and assertions
	// ****************************************************************
	sequence s_tx_write_a;
		!i_mux_mode && !i_nmux.chip_en_n && !i_nmux.wr_n && i_nmux.data_ctrl
		&& i_nmux.chan_a_bn ##1 i_nmux.wr_n;
	endsequence

	sequence s_rx_read_a;
		!i_mux_mode && $fell(i_nmux.rd_n) && !i_nmux.chip_en_n && i_nmux.data_ctrl
		&& i_nmux.chan_a_bn && i_nmux.interrupt_ack_n;
	endsequence

	a_tx_after_rise: assert property (s_tx_write_a |-> ##[2:5] o_tx_load[0])
		else $error("transmit load missing after write strobe rise");
	a_tx_pulse_once: assert property (o_tx_load != 2'h0 && !i_mux_mode |->
		$past(i_nmux.wr_n) && $past(i_nmux.wr_n, 2) ##1 o_tx_load == 2'h0)
		else $error("transmit load early or too long");
	a_rx_on_read: assert property (s_rx_read_a |-> ##[2:5] o_rx_read[0])
		else $error("receive read pulse missing");
	a_oe_after_sync: assert property ($rose(o_data_oe) && !i_mux_mode |->
		$past(i_nmux.rd_n, 2) == 1'b0 && $past(i_nmux.rd_n, 3) == 1'b0)
		else $error("read data driven before strobe was synchronised");
	a_oe_release: assert property (o_data_oe && !i_mux_mode |-> hi_cnt_q <= 4'h6)
		else $error("read data held too long after strobe");
	a_ius_one_new: assert property (new_ius != 6'h00 |->
		$onehot(new_ius) && (new_ius & ~i_pending) == 6'h00)
		else $error("in-service set without a pending source");
	a_ius_needs_chain: assert property (new_ius != 6'h00 && !i_mux_mode |->
		i_chain_enable_in && $past(i_nmux.interrupt_ack_n, 2) == 1'b0)
		else $error("in-service set outside an enabled acknowledge");
	a_int_needs_mie: assert property ($fell(o_int_n) |->
		o_master[MIE_BIT] && (i_pending | $past(i_pending)) != 6'h00)
		else $error("interrupt raised without enable or pending");
endmodule

bind dhp_host_port dhp_host_port_chk chk_u (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_mux_mode(i_mux_mode), .i_nmux(i_nmux),
	.i_chain_enable_in(i_chain_enable_in), .i_pending(i_pending), .o_data_oe(o_data_oe),
	.o_int_n(o_int_n), .o_in_service(o_in_service), .o_tx_load(o_tx_load),
	.o_rx_read(o_rx_read), .o_master(o_master)
);

`default_nettype wire

/* dhp_host_model.sv */
// host bus model driving both bus variants of the register port
`timescale 1ns/1ps
`default_nettype none

module dhp_host_model
	import dhp_pkg::*;
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output var dhp_pkg::dhp_nmux_bus_t o_nmux,
	output var dhp_pkg::dhp_mux_bus_t o_mux,
	output logic [7:0] o_ad
);
	import dhp_pkg::*;

	// ****************************************************************
	// bus cycles
	// ****************************************************************
	// idle bus, nothing selected
	initial
	begin
		o_nmux = 6'h3f;
		o_mux = 6'h3d;
		o_ad = 8'h5a;
	end

	// one strobe held six clocks; six idle clocks keep falls well apart
	task automatic nm_cycle(input logic rd, input logic dc, input logic ch,
		input logic [7:0] wd, output logic [7:0] rv);
		@(posedge i_clk);
		o_nmux.data_ctrl <= dc;
		o_nmux.chan_a_bn <= ch;
		o_nmux.chip_en_n <= 1'b0;
		o_nmux.rd_n <= !rd;
		o_nmux.wr_n <= rd;
		o_ad <= wd;
		repeat (6) @(posedge i_clk);
		rv = i_rdata;
		o_nmux.chip_en_n <= 1'b1;
		o_nmux.rd_n <= 1'b1;
		o_nmux.wr_n <= 1'b1;
		o_ad <= ~wd;
		repeat (6) @(posedge i_clk);
	endtask

	// pointer write, then the access itself
	task automatic nm_reg(input logic rd, input logic ch, input logic [3:0] idx,
		input logic [7:0] wd, output logic [7:0] rv);
		logic [7:0] junk;
		nm_cycle(1'b0, 1'b0, ch,
			{2'b00, (idx[3] ? CMD_POINT_HIGH : 3'h0), idx[2:0]}, junk);
		nm_cycle(rd, 1'b0, ch, wd, rv);
	endtask

	// acknowledge: chain gets time to settle before the read strobe
	task automatic nm_ack(output logic [7:0] rv);
		@(posedge i_clk);
		o_nmux.interrupt_ack_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		nm_cycle(1'b1, 1'b0, 1'b1, 8'h00, rv);
		o_nmux.interrupt_ack_n <= 1'b1;
	endtask

	// multiplexed cycle: address phase, then data phase
	task automatic mx_cycle(input logic rd, input logic [7:0] addr,
		input logic [7:0] wd, output logic [7:0] rv);
		@(posedge i_clk);
		o_mux.cs0_n <= 1'b0;
		o_mux.address_strobe_n <= 1'b0;
		o_ad <= addr;
		repeat (3) @(posedge i_clk);
		o_mux.address_strobe_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_mux.rw <= rd;
		o_mux.cs1 <= 1'b1;
		o_mux.data_strobe_n <= 1'b0;
		o_ad <= rd ? ~addr : wd; // released to the device on reads
		repeat (6) @(posedge i_clk);
		rv = i_rdata;
		o_mux.data_strobe_n <= 1'b1;
		o_mux.cs1 <= 1'b0;
		o_mux.cs0_n <= 1'b1;
		o_ad <= ~o_ad;
		repeat (6) @(posedge i_clk);
	endtask
endmodule

`default_nettype wire

/* testbench.sv */
// self-checking testbench for the host register port
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import dhp_pkg::*;
	// ****************************************************************
	// signals and helpers
	// ****************************************************************
	logic clk, rstn, mux_mode, chain_in, data_oe, int_n, ch, chain_out;
	logic [5:0] pend, in_service_latch;
	dhp_chan_status_t st_a, st_b;
	dhp_nmux_bus_t nmux;
	dhp_mux_bus_t mux;
	logic [7:0] host_ad, ad_wire, rdata, tx_data, vec, master, r, d, v_exp, tx_seen;
	logic [1:0] tx_load, rx_read;
	logic [3:0] idx;
	logic [127:0] wreg_a, wreg_b;
	int failures, num_checks, seed, k, rx_hits;

	dhp_host_port dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_mux_mode(mux_mode),
		.i_nmux(nmux), .i_mux(mux), .i_data(ad_wire), .i_chain_enable_in(chain_in),
		.i_pending(pend), .i_status_a(st_a), .i_status_b(st_b), .o_data(rdata),
		.o_data_oe(data_oe), .o_chain_enable_out(chain_out), .o_int_n(int_n), .o_in_service(in_service_latch),
		.o_tx_load(tx_load), .o_tx_data(tx_data), .o_rx_read(rx_read), .o_vector(vec),
		.o_master(master), .o_wreg_a(wreg_a), .o_wreg_b(wreg_b));
	dhp_host_model host_u (.i_clk(clk), .i_rdata(rdata), .o_nmux(nmux), .o_mux(mux),
		.o_ad(host_ad));

	// shared data wire: the device wins while it drives
	assign ad_wire = data_oe ? rdata : host_ad;

	always #4 clk = ~clk;

	// record transmit bytes and receive reads on channel A
	always @(posedge clk)
	begin
		if (tx_load[0])
			tx_seen <= tx_data;
		if (rx_read[0])
			rx_hits <= rx_hits + 1;
	end

	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// status code merged into the vector, highest pending first
	function automatic logic [2:0] vcode(input logic [5:0] p);
		if (p[5]) return VC_A_RX;
		if (p[4]) return VC_A_TX;
		if (p[3]) return VC_A_EXT;
		if (p[2]) return VC_B_RX;
		if (p[1]) return VC_B_TX;
		if (p[0]) return VC_B_EXT;
		return VC_NONE;
	endfunction

	task automatic do_reset(input logic mm);
		rstn <= 1'b0;
		mux_mode <= mm;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog against a hung sequence
	initial
	begin
		repeat (90000) @(posedge clk);
		failures++;
		give_verdict();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		mux_mode = 1'b0;
		chain_in = 1'b0;
		pend = 6'h00;
		failures = 0;
		num_checks = 0;
		seed = 65085;
		st_a = 48'({$random(seed), $random(seed)});
		st_b = 48'({$random(seed), $random(seed)});
		do_reset(1'b0);
		chk("reset regs a", 0, wreg_a);
		chk("reset regs b", 0, wreg_b);
		chk("reset outputs", {RESET_BYTE, RESET_BYTE, 9'h002},
			{vec, master, data_oe, in_service_latch, int_n, chain_out});
		$display("test reset done");
		for (k = 0; k < 24; k++)
		begin
			ch = 1'($random(seed));
			idx = 4'($random(seed));
			d = 8'($random(seed));
			if (idx inside {IDX_POINTER, IDX_VECTOR, IDX_DATA, IDX_MASTER})
				idx = IDX_BAUD_LO;
			host_u.nm_reg(1'b0, ch, idx, d, r);
			chk("wreg", d, ch ? wreg_a[idx*8 +: 8] : wreg_b[idx*8 +: 8]);
			host_u.nm_cycle(1'b1, 1'b0, ch, 8'h00, r);
			chk("pointer clear", ch ? st_a.line : st_b.line, r);
		end
		for (k = 0; k < 4; k++)
		begin
			d = 8'($random(seed));
			host_u.nm_reg(1'b0, k[0], IDX_BAUD_LO + 4'(k[1]), d, r);
			host_u.nm_reg(1'b1, k[0], IDX_BAUD_LO + 4'(k[1]), 8'h00, r);
			chk("baud", d, r);
		end
		$display("test registers done");
		for (k = 0; k < 2; k++)
		begin
			v_exp = 8'($random(seed));
			host_u.nm_reg(1'b0, k[0], IDX_VECTOR, v_exp, r);
			chk("vector", v_exp, vec);
		end
		host_u.nm_reg(1'b0, 1'b1, IDX_MASTER, 8'h89, r);
		chk("master", 8'h89, master);
		chk("chan a reset", 0, wreg_a);
		pend <= 6'($random(seed));
		host_u.nm_reg(1'b1, 1'b1, IDX_VECTOR, 8'h00, r);
		chk("vector a", v_exp, r);
		host_u.nm_reg(1'b1, 1'b0, IDX_VECTOR, 8'h00, r);
		chk("vector b", {v_exp[7:4], vcode(pend), v_exp[0]}, r);
		host_u.nm_reg(1'b1, 1'b1, IDX_PENDING, 8'h00, r);
		chk("pending a", {2'b00, pend}, r);
		host_u.nm_reg(1'b1, 1'b0, IDX_PENDING, 8'h00, r);
		chk("pending b", 8'h00, r);
		for (k = 0; k < 2; k++)
		begin
			host_u.nm_reg(1'b0, 1'b1, IDX_EXTEN, k[0] ? 8'h04 : 8'h00, r);
			host_u.nm_reg(1'b1, 1'b1, IDX_FRAME_LO, 8'h00, r);
			chk("frame lo", k[0] ? st_a.frame_lo : v_exp, r);
			host_u.nm_reg(1'b1, 1'b1, IDX_FRAME_HI, 8'h00, r);
			chk("frame hi", k[0] ? st_a.frame_hi : {2'b00, pend}, r);
		end
		$display("test shared done");
		d = 8'($random(seed));
		host_u.nm_cycle(1'b0, 1'b1, 1'b1, d, r);
		chk("tx byte", d, tx_seen);
		host_u.nm_cycle(1'b1, 1'b1, 1'b1, 8'h00, r);
		chk("rx byte", {st_a.rx_data, 32'(1)}, {r, 32'(rx_hits)});
		$display("test data done");
		for (k = 0; k < 6; k++)
		begin
			pend <= 6'h01 << k;
			chain_in <= 1'b1;
			host_u.nm_ack(r);
			chk("ack vector", {v_exp[7:4], vcode(6'h01 << k), v_exp[0]}, r);
			chk("in service", 6'h01 << k, in_service_latch);
			chk("chain busy", 2'b10, {int_n, chain_out});
			host_u.nm_cycle(1'b0, 1'b0, 1'b1, {2'b00, CMD_RESET_IUS, 3'h0}, r);
			chk("ius cleared", 6'h00, in_service_latch);
			chk("chain free", 2'b01, {int_n, chain_out});
			chain_in <= 1'b0;
			host_u.nm_ack(r);
			chk("ack blocked", 6'h00, in_service_latch);
			chk("chain cut", 2'b10, {int_n, chain_out});
		end
		$display("test acknowledge done");
		pend <= 6'h00;
		do_reset(1'b1);
		chk("mux reset", 0, wreg_b);
		for (k = 0; k < 2; k++)
		begin
			if (k == 1)
				host_u.mx_cycle(1'b0, 8'hc1, {6'h00, SHIFT_RIGHT}, r);
			d = 8'($random(seed));
			host_u.mx_cycle(1'b0, k ? 8'hb8 : 8'hd9, d, r);
			chk("mux write", d, wreg_b[IDX_BAUD_LO*8 +: 8]);
			host_u.mx_cycle(1'b1, k ? 8'hb8 : 8'hd9, 8'h00, r);
			chk("mux read", d, r);
		end
		$display("test multiplexed done");
		give_verdict();
	end
endmodule

`default_nettype wire
